// ---- verilog/aism_pkg.sv ----
// Purpose: constants for the identity, status and mode register bank
// Assumes: 16-bit registers reached by word address on the internal port
// Notes: identity high nibble and revision byte are parameters of the top
package aism_pkg;
    localparam logic [7:0] ADDR_IDENTITY = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MODE = 8'h02;

    localparam logic [3:0] CHANNEL_QUANTITY = 4'h6;
    localparam int CHANNELS = 6;

    localparam logic [15:0] STATUS_RESET = 16'h0500;
    localparam logic [15:0] MODE_RESET = 16'h0510;
    // reserved mode bits 15:14 always read zero
    localparam logic [15:0] MODE_WRITE_MASK = 16'h3fff;

    // status bit positions
    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_MAP_CHANGED = 13;
    localparam int ST_INPUT_ERR = 12;

    // mode bit positions, shared by the mirrored status fields
    localparam int MD_MAP_CRC_EN = 13;
    localparam int MD_INPUT_CRC_EN = 12;
    localparam int MD_CRC_TYPE = 11;
    localparam int MD_RESET_FLAG = 10;
    localparam int MD_WORD_HI = 9;
    localparam int MD_WORD_LO = 8;
    localparam int MD_TIMEOUT_EN = 4;
    localparam int MD_SEL_HI = 3;
    localparam int MD_SEL_LO = 2;
    localparam int MD_IDLE_FLOAT = 1;
    localparam int MD_PULSE_FMT = 0;

    localparam logic [1:0] SEL_LAGGING = 2'h0;
    localparam logic [1:0] SEL_ANY = 2'h1;

    localparam int READY_PULSE_CYCLES = 4;
endpackage : aism_pkg

// ---- verilog/aism_regs.sv ----
// Purpose: identity, status and mode registers plus sample-ready pin driver
// Assumes: the serial frame logic presents decoded word reads and writes
// Notes: sticky status flags and new-sample flags clear on a status read
//
// Behaviour
// - identity bits 11:8 read fixed 0110b
// - identity bits 7:0 hold revision byte
// - status register at 01h, resets 0500h
// - status bit 15 shows interface lock
// - status bit 14 set on each resync
// - status bit 13 set on map checksum change
// - status bit 12 set on input checksum error
// - status bit 11 shows checksum polynomial
// - status bit 10 shows reset occurred
// - status bits 9:8 show word length
// - status bits 5:0 per-channel new sample flags
// - mode register at 02h, resets 0510h
// - mode upper fields at documented bit positions
// - mode lower fields at documented bit positions
// - writing reset flag zero clears reset indication
// - ready pin source follows select field
// - ready pin idle, level and pulse formats
`timescale 1ns/100ps
`default_nettype none
module aism_regs #(
    parameter logic [3:0] ID_FAMILY = 4'h0,     // arbitrary value
    parameter logic [7:0] REVISION = 8'h00,     // arbitrary value
    parameter int PULSE_CYCLES = aism_pkg::READY_PULSE_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic iface_locked_in,
    input wire logic resync_evt_in,
    input wire logic map_crc_changed_in,
    input wire logic input_crc_err_in,
    input wire logic [5:0] new_sample_evt_in,
    input wire logic [5:0] chan_enable_in,
    output logic [15:0] reg_rdata_out,
    output logic [15:0] mode_cfg_out,
    output logic sample_ready_pin_out,
    output logic sample_ready_pin_oe_out
);
    logic [15:0] mode;
    logic [15:0] rdata;
    logic lock;
    logic resync_occurred_flag;
    logic map_changed;
    logic input_err;
    logic [5:0] new_sample_flag;
    logic status_read;
    logic data_avail;
    logic data_avail_d;
    logic [7:0] pulse_cnt;
    logic [15:0] status_word;
    logic [15:0] identity_word;

    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    assign status_read = reg_rd_in && (reg_addr_in == aism_pkg::ADDR_STATUS);
    assign identity_word = {ID_FAMILY, aism_pkg::CHANNEL_QUANTITY, REVISION};

    // mirrored fields come from the mode register, not copies
    assign status_word = {lock, resync_occurred_flag, map_changed, input_err,
                          mode[aism_pkg::MD_CRC_TYPE],
                          mode[aism_pkg::MD_RESET_FLAG],
                          mode[aism_pkg::MD_WORD_HI:aism_pkg::MD_WORD_LO],
                          2'h0, new_sample_flag};

    // only the mode address is writable; others drop silently
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode <= aism_pkg::MODE_RESET;
        end else if (reg_wr_in && reg_addr_in == aism_pkg::ADDR_MODE) begin
            mode <= reg_wdata_in & aism_pkg::MODE_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lock <= 1'b0;
        end else begin
            lock <= iface_locked_in;
        end
    end

    // a set in the clearing cycle survives
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            resync_occurred_flag <= 1'b0;
            map_changed <= 1'b0;
            input_err <= 1'b0;
            new_sample_flag <= 6'h00;
        end else begin
            resync_occurred_flag <= sticky(resync_occurred_flag, resync_evt_in, status_read);
            map_changed <= sticky(map_changed, map_crc_changed_in, status_read);
            input_err <= sticky(input_err, input_crc_err_in, status_read);
            for (int i = 0; i < aism_pkg::CHANNELS; i++) begin
                new_sample_flag[i] <= sticky(new_sample_flag[i], new_sample_evt_in[i],
                                             status_read);
            end
        end
    end

    always_comb begin
        case (reg_addr_in)
            aism_pkg::ADDR_IDENTITY: rdata = identity_word;
            aism_pkg::ADDR_STATUS: rdata = status_word;
            aism_pkg::ADDR_MODE: rdata = mode;
            default: rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_cfg_out <= aism_pkg::MODE_RESET;
        end else begin
            mode_cfg_out <= mode;
        end
    end

    // lagging waits for every enabled channel; any other select takes the first
    always_comb begin
        case (mode[aism_pkg::MD_SEL_HI:aism_pkg::MD_SEL_LO])
            aism_pkg::SEL_LAGGING:
                data_avail = (chan_enable_in != 6'h00) &&
                             ((new_sample_flag & chan_enable_in) == chan_enable_in);
            aism_pkg::SEL_ANY: data_avail = |(new_sample_flag & chan_enable_in);
            default: data_avail = |(new_sample_flag & chan_enable_in);
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_avail_d <= 1'b0;
            pulse_cnt <= 8'h00;
        end else begin
            data_avail_d <= data_avail;
            if (data_avail && !data_avail_d) begin
                pulse_cnt <= 8'(PULSE_CYCLES);
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end

    // low while data stands, or for the pulse only in pulse format
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sample_ready_pin_out <= 1'b1;
            sample_ready_pin_oe_out <= 1'b1;
        end else if (mode[aism_pkg::MD_PULSE_FMT] ? (pulse_cnt != 8'h00) : data_avail) begin
            sample_ready_pin_out <= 1'b0;
            sample_ready_pin_oe_out <= 1'b1;
        end else begin
            sample_ready_pin_out <= 1'b1;
            sample_ready_pin_oe_out <= ~mode[aism_pkg::MD_IDLE_FLOAT];
        end
    end

    chk_identity_count: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == aism_pkg::ADDR_IDENTITY |=> reg_rdata_out[11:8] == 4'h6)
        else $error("identity channel count wrong");
    chk_revision_byte: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == aism_pkg::ADDR_IDENTITY |=> reg_rdata_out[7:0] == REVISION)
        else $error("identity revision byte wrong");
    chk_status_rsvd: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == aism_pkg::ADDR_STATUS |=> reg_rdata_out[7:6] == 2'h0)
        else $error("status reserved bits not zero");
    chk_resync_set: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        resync_evt_in |=> resync_occurred_flag)
        else $error("resync flag not set");
    chk_err_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        input_err && !status_read |=> input_err)
        else $error("input error flag lost");
    chk_map_set: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !map_changed && !map_crc_changed_in |=> !map_changed)
        else $error("map changed flag set without cause");
    chk_lock_follow: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        iface_locked_in ##1 iface_locked_in |=> status_word[aism_pkg::ST_LOCK])
        else $error("lock bit not following");
    chk_reset_clear: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == aism_pkg::ADDR_MODE && !reg_wdata_in[10]
        |=> !status_word[aism_pkg::MD_RESET_FLAG])
        else $error("reset indication not cleared");
    chk_mirror_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_rd_in && !reg_wr_in && reg_addr_in == aism_pkg::ADDR_STATUS
        |=> reg_rdata_out[aism_pkg::MD_CRC_TYPE:aism_pkg::MD_WORD_LO] ==
            mode[aism_pkg::MD_CRC_TYPE:aism_pkg::MD_WORD_LO])
        else $error("status mirror differs from mode");
    chk_ro_ignored: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in != aism_pkg::ADDR_MODE |=> $stable(mode))
        else $error("read-only write changed mode");
    chk_mode_rsvd: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        mode[15:14] == 2'h0)
        else $error("mode reserved bits set");
    chk_level_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        data_avail && !mode[aism_pkg::MD_PULSE_FMT]
        |=> !sample_ready_pin_out && sample_ready_pin_oe_out)
        else $error("ready pin not driven low");
    chk_idle_float: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !data_avail && mode[aism_pkg::MD_IDLE_FLOAT] && pulse_cnt == 8'h00
        |=> !sample_ready_pin_oe_out)
        else $error("ready pin not floated when idle");
    chk_lag_select: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        mode[aism_pkg::MD_SEL_HI:aism_pkg::MD_SEL_LO] == aism_pkg::SEL_LAGGING &&
        !mode[aism_pkg::MD_PULSE_FMT] && ((new_sample_flag & chan_enable_in) != chan_enable_in)
        |=> sample_ready_pin_out)
        else $error("lagging select asserted early");
endmodule : aism_regs
`default_nettype wire

// ---- dv/aism_evt_model.sv ----
// Purpose: stand-in for frame logic and converter event sources
// Assumes: requests set after a rising edge, launched at the next falling edge
// Notes: one-cycle pulses, as the real sources give
`timescale 1ns/100ps
`default_nettype none
module aism_evt_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic lock_in,
    input wire logic [9:0] vec_in,
    output logic locked_out,
    output logic [9:0] evt_out
);
    // launched on the falling edge so the block sees a clean setup
    initial begin
        locked_out = 1'b0;
        evt_out = 10'h000;
        forever begin
            @(negedge clk_in);
            locked_out <= lock_in;
            evt_out <= go_in ? vec_in : 10'h000;
        end
    end
endmodule : aism_evt_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: register and ready pin checks of the register bank
// Assumes: single-cycle read and write strobes, inputs set on falling edge
// Notes: pulse length shortened to 3 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic sys_clk_in, resetn_in, wr, rd_s, go, lk, locked, pin, oe;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, mode_cfg;
    logic [9:0] vec, evt;
    logic [5:0] en;
    int bad_count = 0;
    int comparisons = 0;
    int lows;
    aism_regs #(.ID_FAMILY(4'h3), .REVISION(8'h5a), .PULSE_CYCLES(3)) i_dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd_s),
        .iface_locked_in(locked), .resync_evt_in(evt[9]), .map_crc_changed_in(evt[8]),
        .input_crc_err_in(evt[7]), .new_sample_evt_in(evt[5:0]), .chan_enable_in(en),
        .reg_rdata_out(rdata), .mode_cfg_out(mode_cfg), .sample_ready_pin_out(pin),
        .sample_ready_pin_oe_out(oe));
    aism_evt_model i_evt (.clk_in(sys_clk_in), .go_in(go), .lock_in(lk), .vec_in(vec),
        .locked_out(locked), .evt_out(evt));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic rd(input logic [7:0] a, input logic [15:0] ex);
        @(negedge sys_clk_in);
        addr = a;
        rd_s = 1'b1;
        @(negedge sys_clk_in);
        rd_s = 1'b0;
        `CHK("read data", ex, rdata)
    endtask : rd
    task automatic wrt(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk_in);
        wr = 1'b0;
    endtask : wrt
    task automatic ev(input logic [9:0] v);
        @(posedge sys_clk_in);
        go <= 1'b1;
        vec <= v;
        lk <= 1'b1;
        @(posedge sys_clk_in);
        go <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
    endtask : ev
    task automatic pin_chk(input logic ep, input logic eo);
        repeat (2) @(negedge sys_clk_in);
        `CHK("ready pin", ep, pin)
        `CHK("ready enable", eo, oe)
    endtask : pin_chk
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end
    initial begin
        resetn_in = 1'b0;
        {wr, rd_s, go, lk, addr, wdata, vec} = '0;
        en = 6'h3f;
        repeat (5) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        `CHK("mode copy", aism_pkg::MODE_RESET, mode_cfg)
        rd(aism_pkg::ADDR_IDENTITY, 16'h365a);
        rd(aism_pkg::ADDR_STATUS, 16'h0500);
        rd(aism_pkg::ADDR_MODE, 16'h0510);
        rd(8'h07, 16'h0000);
        wrt(aism_pkg::ADDR_IDENTITY, 16'hffff);
        wrt(aism_pkg::ADDR_STATUS, 16'hffff);
        rd(aism_pkg::ADDR_IDENTITY, 16'h365a);
        rd(aism_pkg::ADDR_STATUS, 16'h0500);
        ev(10'h380);
        rd(aism_pkg::ADDR_STATUS, 16'hf500);
        rd(aism_pkg::ADDR_STATUS, 16'h8500);
        wrt(aism_pkg::ADDR_MODE, 16'hfbef);
        rd(aism_pkg::ADDR_MODE, 16'h3bef);
        `CHK("mode copy", 16'h3bef, mode_cfg)
        rd(aism_pkg::ADDR_STATUS, 16'h8b00);
        for (int i = 0; i < 4; i++) begin
            wrt(aism_pkg::ADDR_MODE, {4'h0, i[0], 1'b0, i[1:0], 8'h10});
            rd(aism_pkg::ADDR_STATUS, {4'h8, i[0], 1'b0, i[1:0], 8'h00});
        end
        wrt(aism_pkg::ADDR_MODE, 16'h0000);
        ev(10'h001);
        pin_chk(1'b1, 1'b1);
        wrt(aism_pkg::ADDR_MODE, 16'h0004);
        pin_chk(1'b0, 1'b1);
        rd(aism_pkg::ADDR_STATUS, 16'h8001);
        pin_chk(1'b1, 1'b1);
        wrt(aism_pkg::ADDR_MODE, 16'h0002);
        pin_chk(1'b1, 1'b0);
        wrt(aism_pkg::ADDR_MODE, 16'h0000);
        ev(10'h03f);
        pin_chk(1'b0, 1'b1);
        rd(aism_pkg::ADDR_STATUS, 16'h803f);
        // only channel 0 enabled: a flag on a disabled channel must not count
        en = 6'h01;
        ev(10'h002);
        pin_chk(1'b1, 1'b1);
        ev(10'h001);
        pin_chk(1'b0, 1'b1);
        rd(aism_pkg::ADDR_STATUS, 16'h8003);
        en = 6'h3f;
        wrt(aism_pkg::ADDR_MODE, 16'h000c);
        ev(10'h010);
        pin_chk(1'b0, 1'b1);
        rd(aism_pkg::ADDR_STATUS, 16'h8010);
        wrt(aism_pkg::ADDR_MODE, 16'h0008);
        ev(10'h020);
        pin_chk(1'b0, 1'b1);
        rd(aism_pkg::ADDR_STATUS, 16'h8020);
        wrt(aism_pkg::ADDR_MODE, 16'h0001);
        ev(10'h03f);
        lows = 0;
        repeat (12) begin
            @(negedge sys_clk_in);
            if (pin === 1'b0)
                lows++;
        end
        `CHK("pulse cycles", 3, lows)
        `CHK("pin after pulse", 1'b1, pin)
        // second reset mid-run: reset indication and defaults must return
        lk = 1'b0;
        resetn_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        `CHK("mode copy", aism_pkg::MODE_RESET, mode_cfg)
        `CHK("ready pin", 1'b1, pin)
        rd(aism_pkg::ADDR_MODE, 16'h0510);
        rd(aism_pkg::ADDR_STATUS, 16'h0500);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
